// file: core/can_mode_wake.sv
// mode selection, remote wake detection and receive gating of a can transceiver
`include "can_mode_cfg.svh"
`default_nettype none
module can_mode_wake #(
  parameter int unsigned PHASE_CYC = `WAKE_PHASE_CYC,
  parameter int unsigned FILTER_CYC = `WAKE_FILTER_CYC,
  parameter int unsigned TIMEOUT_CYC = `WAKE_TIMEOUT_CYC,
  parameter int unsigned STARTUP_CYC = `RX_STARTUP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic transmit_data,
  input wire logic standby_select,
  input wire logic bus_dominant,
  input wire logic core_supply_low,
  input wire logic io_supply_low,
  output logic bus_drive_dominant,
  output logic bus_bias_ground,
  output logic bus_high_line_oe,
  output logic bus_low_line_oe,
  output logic receive_data,
  output logic receive_data_oe,
  output logic wake_detected,
  output logic [1:0] op_mode
);
  // two-flop synchronisers for pins and supply flags
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic txd_s;
  logic stb_s;
  logic bus_s;
  logic core_low_s;
  logic io_low_s;
  assign txd_s = sync2[0];
  assign stb_s = sync2[1];
  assign bus_s = sync2[2];
  assign core_low_s = sync2[3];
  assign io_low_s = sync2[4];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= 5'h1b;
      sync2 <= 5'h1b;
    end
    else
    begin
      sync1 <= {io_supply_low, core_supply_low, bus_dominant, standby_select, transmit_data};
      sync2 <= sync1;
    end
  end

  // filtered bus seen by the low-power receiver
  logic bus_f;
  bus_phase_filter #(
    .FILTER_CYC(FILTER_CYC)
  ) u_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw_dominant(bus_s),
    .filt_dominant(bus_f)
  );

  // mode selection
  can_mode_pkg::op_mode_e mode;
  can_mode_pkg::op_mode_e next_mode;

  always_comb
  begin
    if (io_low_s)
      next_mode = can_mode_pkg::mode_off;
    else if (core_low_s)
      next_mode = can_mode_pkg::mode_standby;
    else if (stb_s)
      next_mode = can_mode_pkg::mode_standby;
    else
      next_mode = can_mode_pkg::mode_normal;
  end

  // wake pattern detector
  can_mode_pkg::wake_state_e wst;
  can_mode_pkg::wake_state_e next_wst;
  logic [15:0] phase_cnt;
  logic [15:0] next_phase_cnt;
  logic [31:0] tmo_cnt;
  logic [31:0] next_tmo_cnt;
  logic [15:0] start_cnt;
  logic [15:0] next_start_cnt;
  logic woken;
  logic next_woken;
  logic rx_live;
  logic next_rx_live;
  logic in_standby;
  assign in_standby = (mode == can_mode_pkg::mode_standby);

  function automatic logic phase_done(input logic [15:0] cnt);
    phase_done = (cnt >= 16'(PHASE_CYC - 1));
  endfunction : phase_done

  always_comb
  begin
    next_wst = wst;
    next_phase_cnt = 16'h0000;
    next_tmo_cnt = 32'h0;
    next_start_cnt = start_cnt;
    next_woken = woken;
    next_rx_live = rx_live;
    if (!in_standby || next_mode != can_mode_pkg::mode_standby)
    begin
      // leaving standby aborts the pattern and drops the wake
      next_wst = can_mode_pkg::wk_idle;
      next_woken = 1'b0;
      next_rx_live = 1'b0;
      next_start_cnt = 16'h0000;
    end
    else if (woken)
    begin
      if (start_cnt >= 16'(STARTUP_CYC - 1))
        next_rx_live = 1'b1;
      else
        next_start_cnt = start_cnt + 16'h0001;
    end
    else
    begin
      // the detector runs on the io supply alone
      if (wst != can_mode_pkg::wk_idle)
        next_tmo_cnt = tmo_cnt + 32'h1;
      case (wst)
        can_mode_pkg::wk_idle:
        begin
          if (bus_f)
          begin
            next_phase_cnt = 16'h0001;
            next_wst = can_mode_pkg::wk_dom1;
            next_tmo_cnt = 32'h1;
          end
        end
        can_mode_pkg::wk_dom1:
        begin
          // hold count through short recessive gaps
          if (bus_f)
            next_phase_cnt = phase_done(phase_cnt) ? phase_cnt : phase_cnt + 16'h0001;
          else if (phase_done(phase_cnt))
            next_wst = can_mode_pkg::wk_rec;
          else
            next_phase_cnt = phase_cnt;
          if (!bus_f && phase_done(phase_cnt))
            next_phase_cnt = 16'h0001;
        end
        can_mode_pkg::wk_rec:
        begin
          if (!bus_f)
            next_phase_cnt = phase_done(phase_cnt) ? phase_cnt : phase_cnt + 16'h0001;
          else if (phase_done(phase_cnt))
          begin
            next_wst = can_mode_pkg::wk_dom2;
            next_phase_cnt = 16'h0001;
          end
          else
            next_phase_cnt = phase_cnt;
        end
        can_mode_pkg::wk_dom2:
        begin
          if (bus_f)
          begin
            next_phase_cnt = phase_cnt + 16'h0001;
            if (phase_done(phase_cnt))
            begin
              next_woken = 1'b1;
              next_wst = can_mode_pkg::wk_idle;
              next_start_cnt = 16'h0000;
            end
          end
          else
            next_phase_cnt = phase_cnt;
        end
        default:
          next_wst = can_mode_pkg::wk_idle;
      endcase
      if (wst != can_mode_pkg::wk_idle && tmo_cnt >= TIMEOUT_CYC - 1)
      begin
        next_wst = can_mode_pkg::wk_idle;
        next_woken = 1'b0;
        next_tmo_cnt = 32'h0;
        next_phase_cnt = 16'h0000;
      end
    end
  end

  // pin outputs
  logic next_drive;
  logic next_bias;
  logic next_bus_oe;
  logic next_rxd;
  logic next_rxd_oe;

  always_comb
  begin
    next_drive = 1'b0;
    next_bias = 1'b0;
    next_bus_oe = 1'b0;
    next_rxd = 1'b1;
    next_rxd_oe = 1'b0;
    case (mode)
      can_mode_pkg::mode_normal:
      begin
        next_drive = !txd_s;
        next_bus_oe = 1'b1;
        next_rxd = !bus_s;
        next_rxd_oe = 1'b1;
      end
      can_mode_pkg::mode_standby:
      begin
        next_bias = 1'b1;
        next_bus_oe = 1'b1;
        next_rxd = rx_live ? !bus_f : 1'b1;
        next_rxd_oe = 1'b1;
      end
      can_mode_pkg::mode_off:
      begin
        next_bus_oe = 1'b0;
        next_rxd_oe = 1'b0;
      end
      default:
      begin
        next_bus_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode <= can_mode_pkg::mode_off;
      wst <= can_mode_pkg::wk_idle;
      phase_cnt <= 16'h0000;
      tmo_cnt <= 32'h0;
      start_cnt <= 16'h0000;
      woken <= 1'b0;
      rx_live <= 1'b0;
      bus_drive_dominant <= 1'b0;
      bus_bias_ground <= 1'b0;
      bus_high_line_oe <= 1'b0;
      bus_low_line_oe <= 1'b0;
      receive_data <= 1'b1;
      receive_data_oe <= 1'b0;
      wake_detected <= 1'b0;
      op_mode <= 2'h0;
    end
    else
    begin
      mode <= next_mode;
      wst <= next_wst;
      phase_cnt <= next_phase_cnt;
      tmo_cnt <= next_tmo_cnt;
      start_cnt <= next_start_cnt;
      woken <= next_woken;
      rx_live <= next_rx_live;
      bus_drive_dominant <= next_drive;
      bus_bias_ground <= next_bias;
      bus_high_line_oe <= next_bus_oe;
      bus_low_line_oe <= next_bus_oe;
      receive_data <= next_rxd;
      receive_data_oe <= next_rxd_oe;
      wake_detected <= woken;
      op_mode <= mode;
    end
  end
endmodule : can_mode_wake
`default_nettype wire

// file: inc/can_mode_cfg.svh
// timing constants for transceiver mode and wake logic
`ifndef CAN_MODE_CFG_SVH
`define CAN_MODE_CFG_SVH
`define CLK_PERIOD_NS 10
// wake phase qualification window 0.5 us .. 1.8 us; 1.0 us chosen
`define WAKE_PHASE_NS 1000
`define WAKE_PHASE_CYC (`WAKE_PHASE_NS / `CLK_PERIOD_NS)
// wake filter time, at most 1.8 us; 0.8 us chosen
`define WAKE_FILTER_NS 800
`define WAKE_FILTER_CYC (`WAKE_FILTER_NS / `CLK_PERIOD_NS)
// wake timeout 0.8 ms .. 9 ms; 2 ms chosen
`define WAKE_TIMEOUT_US 2000
`define WAKE_TIMEOUT_CYC ((`WAKE_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
// receive start-up delay 4 us .. 20 us; 10 us chosen
`define RX_STARTUP_US 10
`define RX_STARTUP_CYC ((`RX_STARTUP_US * 1000) / `CLK_PERIOD_NS)
`endif

// file: inc/can_mode_pkg.sv
// types for transceiver mode and wake logic
`default_nettype none
package can_mode_pkg;
  typedef enum logic [1:0] {mode_off, mode_standby, mode_normal} op_mode_e;
  typedef enum logic [1:0] {wk_idle, wk_dom1, wk_rec, wk_dom2} wake_state_e;
endpackage : can_mode_pkg
`default_nettype wire

// file: core/bus_phase_filter.sv
// bus level filter: output changes only after a stable run of filter cycles
`include "can_mode_cfg.svh"
`default_nettype none
module bus_phase_filter #(
  parameter int unsigned FILTER_CYC = `WAKE_FILTER_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic raw_dominant,
  output logic filt_dominant
);
  logic [15:0] run;
  logic [15:0] next_run;
  logic next_filt_dominant;

  always_comb
  begin
    next_run = 16'h0000;
    next_filt_dominant = filt_dominant;
    if (raw_dominant != filt_dominant)
    begin
      next_run = run + 16'h0001;
      if (run >= 16'(FILTER_CYC - 1))
      begin
        next_filt_dominant = raw_dominant;
        next_run = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      run <= 16'h0000;
      filt_dominant <= 1'b0;
    end
    else
    begin
      run <= next_run;
      filt_dominant <= next_filt_dominant;
    end
  end
endmodule : bus_phase_filter
`default_nettype wire

// file: tb/can_mode_wake_chk.sv
// assertion checker for the transceiver mode and wake logic
`default_nettype none
module can_mode_wake_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic transmit_data,
  input wire logic standby_select,
  input wire logic bus_dominant,
  input wire logic core_supply_low,
  input wire logic io_supply_low,
  input wire logic bus_drive_dominant,
  input wire logic bus_bias_ground,
  input wire logic bus_high_line_oe,
  input wire logic bus_low_line_oe,
  input wire logic receive_data,
  input wire logic receive_data_oe,
  input wire logic wake_detected,
  input wire logic [1:0] op_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_io_low_off: assert property (io_supply_low [*4] |=> op_mode == 2'h0)
    else $error("mode not off with io supply low");
  a_core_low_standby: assert property
    ((!io_supply_low && core_supply_low) [*4] |=> op_mode == 2'h1)
    else $error("mode not standby with core supply low");
  a_select_low_normal: assert property
    ((!io_supply_low && !core_supply_low && !standby_select) [*4] |=> op_mode == 2'h2)
    else $error("mode not normal with select low");
  a_select_high_standby: assert property
    ((!io_supply_low && !core_supply_low && standby_select) [*4] |=> op_mode == 2'h1)
    else $error("mode not standby with select high");
  a_off_high_z: assert property
    (op_mode == 2'h0 |-> !bus_high_line_oe && !bus_low_line_oe && !receive_data_oe)
    else $error("pins driven in off mode");
  a_standby_no_drive: assert property
    (op_mode == 2'h1 |-> !bus_drive_dominant && bus_bias_ground)
    else $error("bus driven in standby");
  a_normal_tx_drive: assert property
    ((op_mode == 2'h2 && !transmit_data) [*3] |=> op_mode != 2'h2 || bus_drive_dominant)
    else $error("low transmit not driven dominant");
  a_normal_rx_follow: assert property
    ((op_mode == 2'h2 && bus_dominant) [*3] |=> op_mode != 2'h2 || !receive_data)
    else $error("receive not low on dominant bus");
  a_rx_high_no_wake: assert property
    (op_mode == 2'h1 && $past(op_mode) == 2'h1 && !wake_detected |-> receive_data)
    else $error("receive low in standby before wake");
  a_startup_rx_high: assert property ($rose(wake_detected) |-> receive_data [*8])
    else $error("receive low during start-up delay");
endmodule : can_mode_wake_chk
bind can_mode_wake can_mode_wake_chk can_mode_wake_chk_inst (.sys_clk, .rst, .transmit_data,
  .standby_select, .bus_dominant, .core_supply_low, .io_supply_low, .bus_drive_dominant,
  .bus_bias_ground, .bus_high_line_oe, .bus_low_line_oe, .receive_data, .receive_data_oe,
  .wake_detected, .op_mode);
`default_nettype wire

// file: tb/can_ctrl_model.sv
// protocol controller model driving transmit and standby select
`default_nettype none
module can_ctrl_model (
  input wire logic sys_clk,
  input wire logic want_normal,
  input wire logic tx_bit,
  output logic transmit_data,
  output logic standby_select
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    transmit_data = 1'b1;
    standby_select = 1'b1;
  end
  // select low asks for normal mode
  always @(negedge sys_clk)
  begin
    standby_select <= !want_normal;
    transmit_data <= tx_bit;
  end
endmodule : can_ctrl_model
`default_nettype wire

// file: tb/can_mode_wake_bench.sv
// self-checking bench for the transceiver mode and wake logic
`default_nettype none
module can_mode_wake_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TO_CYC = 2000;
  localparam int unsigned SU_CYC = 50;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic want_normal = 1'b0;
  logic tx_bit = 1'b1;
  logic bus_dominant = 1'b0;
  logic core_supply_low = 1'b0;
  logic io_supply_low = 1'b0;
  logic transmit_data, standby_select, bus_drive_dominant, bus_bias_ground;
  logic bus_high_line_oe, bus_low_line_oe, receive_data, receive_data_oe, wake_detected;
  logic [1:0] op_mode;
  int fails = 0;
  int check_count = 0;
  always #5 sys_clk = ~sys_clk;
  can_ctrl_model can_ctrl_model_inst (.sys_clk, .want_normal, .tx_bit, .transmit_data,
    .standby_select);
  can_mode_wake #(.TIMEOUT_CYC(TO_CYC), .STARTUP_CYC(SU_CYC)) can_mode_wake_inst (.sys_clk,
    .rst, .transmit_data, .standby_select, .bus_dominant, .core_supply_low, .io_supply_low,
    .bus_drive_dominant, .bus_bias_ground, .bus_high_line_oe, .bus_low_line_oe,
    .receive_data, .receive_data_oe, .wake_detected, .op_mode);
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic bus(input logic lvl, input int n);
    bus_dominant = lvl;
    cyc(n);
  endtask : bus
  task automatic wait_wake(input logic exp);
    for (int k = 0; k < 300 && wake_detected !== 1'b1; k++)
      cyc(1);
    chk(wake_detected, exp);
  endtask : wait_wake
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic t_reset();
    chk(op_mode, 2'h0);
    chk({bus_high_line_oe, receive_data_oe}, 2'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes();
    logic [1:0] exp;
    for (int i = 0; i < 8; i++)
    begin
      io_supply_low = i[2];
      core_supply_low = i[1];
      want_normal = !i[0];
      cyc(6);
      exp = i[2] ? 2'h0 : ((i[1] || i[0]) ? 2'h1 : 2'h2);
      chk(op_mode, exp);
      chk({bus_low_line_oe, receive_data_oe}, i[2] ? 2'h0 : 2'h3);
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_normal();
    io_supply_low = 1'b0;
    core_supply_low = 1'b0;
    want_normal = 1'b1;
    cyc(6);
    for (int v = 0; v < 2; v++)
    begin
      tx_bit = v[0];
      bus_dominant = !v[0];
      cyc(5);
      chk(bus_drive_dominant, !v[0]);
      chk(receive_data, v[0]);
    end
    want_normal = 1'b0;
    tx_bit = 1'b0;
    bus_dominant = 1'b0;
    cyc(8);
    chk({bus_drive_dominant, bus_bias_ground}, 2'h1);
    chk(receive_data, 1'b1);
    tx_bit = 1'b1;
    $display("test normal done");
  endtask : t_normal
  task automatic t_wake();
    bus(1'b1, 120);
    bus(1'b0, 120);
    bus_dominant = 1'b1;
    wait_wake(1'b1);
    chk(receive_data, 1'b1);
    bus(1'b0, SU_CYC + 50);
    chk(receive_data, 1'b1);
    bus(1'b1, 120);
    chk(receive_data, 1'b0);
    for (int k = 0; k < 70; k++)
    begin
      bus_dominant = (k >= 40);
      cyc(1);
      chk(receive_data, 1'b0);
    end
    want_normal = 1'b1;
    cyc(6);
    chk(op_mode, 2'h2);
    chk(wake_detected, 1'b0);
    bus_dominant = 1'b0;
    want_normal = 1'b0;
    cyc(8);
    $display("test wake done");
  endtask : t_wake
  task automatic t_timeout();
    bus(1'b1, 120);
    bus(1'b0, TO_CYC + 100);
    bus(1'b1, 300);
    chk(wake_detected, 1'b0);
    bus(1'b0, 120);
    bus_dominant = 1'b1;
    wait_wake(1'b1);
    $display("test timeout done");
  endtask : t_timeout
  initial
  begin
    cyc(16);
    t_reset();
    rst = 1'b0;
    t_modes();
    t_normal();
    t_wake();
    t_timeout();
    summarize();
  end
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
endmodule : can_mode_wake_bench
`default_nettype wire
